/* File: src/dual_slope_pwm_timer16.sv */
// 16-bit dual-slope pwm timer with two compare channels
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "dual_slope_pwm_cfg.svh"

module dual_slope_pwm_timer16
    import dual_slope_pwm_pkg::*;
#(
    parameter bit EXTRA_DIV = 1'b1 // instance offers divide by 16 and 32
)
(
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic srst, // synchronous reset, active high
    input wire regReq_s req, // register bus request
    output logic [15:0] rdata, // read data, cycle after read strobe
    output logic [3:0] flags, // sticky event flags
    output pinDrive_s pins // wave pin level and drive enable
);

    timerState_s st;
    timerState_s next_st;
    logic tick;
    logic dual;
    logic pfc;
    logic [15:0] top;
    logic [15:0] fixMask;
    logic [9:0] divMask;
    logic atTop;
    logic atBottom;
    logic upEff;
    logic [3:0] clr;
    logic [3:0] set;
    logic [1:0] match;
    logic [1:0][1:0] act;
    logic [1:0] connected;

    // prescaler divide mask; 16 and 32 only on the extended instance
    always_comb
    begin
        case (st.clkSel)
            `PWM_CLK_DIV1: divMask = `PWM_MASK_DIV1;
            `PWM_CLK_DIV8: divMask = `PWM_MASK_DIV8;
            `PWM_CLK_DIV64: divMask = `PWM_MASK_DIV64;
            `PWM_CLK_DIV256: divMask = `PWM_MASK_DIV256;
            `PWM_CLK_DIV1024: divMask = `PWM_MASK_DIV1024;
            `PWM_CLK_DIV16: divMask = `PWM_MASK_DIV16;
            `PWM_CLK_DIV32: divMask = `PWM_MASK_DIV32;
            default: divMask = `PWM_MASK_DIV1;
        endcase
    end

    // tick is a clock enable, never a clock of its own
    assign tick = (st.clkSel != `PWM_CLK_STOP)
        && (EXTRA_DIV || st.clkSel < `PWM_CLK_DIV16)
        && ((st.psc & divMask) == divMask);

    // top source and mode class
    always_comb
    begin
        dual = 1'b1;
        pfc = 1'b0;
        fixMask = 16'hffff;
        case (st.mode)
            `PWM_MODE_PC8:
            begin
                top = `PWM_TOP_8BIT;
                fixMask = `PWM_TOP_8BIT;
            end
            `PWM_MODE_PC9:
            begin
                top = `PWM_TOP_9BIT;
                fixMask = `PWM_TOP_9BIT;
            end
            `PWM_MODE_PC10:
            begin
                top = `PWM_TOP_10BIT;
                fixMask = `PWM_TOP_10BIT;
            end
            `PWM_MODE_PFC_CAP:
            begin
                top = st.capTop;
                pfc = 1'b1;
            end
            `PWM_MODE_PFC_A:
            begin
                top = st.actCmp[0];
                pfc = 1'b1;
            end
            `PWM_MODE_PC_CAP: top = st.capTop;
            `PWM_MODE_PC_A: top = st.actCmp[0];
            default:
            begin
                top = 16'hffff;
                dual = 1'b0;
            end
        endcase
    end

    // turning points; a missed top wraps through 0xffff
    assign atTop = (st.dir == COUNT_UP) && (st.cnt == top);
    assign atBottom = (st.dir == COUNT_DOWN)
        && (st.cnt == 16'h0000);
    // ends count as the slope that keeps the level: zero low, top high
    assign upEff = (st.cnt == 16'h0000) ? 1'b1 :
        ((st.cnt == top) ? 1'b0 : (st.dir == COUNT_UP));

    // per-channel match and pin connection
    assign act[0] = st.actA;
    assign act[1] = st.actB;
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : gChan
            // a compare above top is reached only after a missed top
            assign match[ch] = dual && tick
                && (st.cnt == st.actCmp[ch]);
            // toggle is for A only, with mode bit 3; B reserved
            assign connected[ch] = dual
                && (act[ch][1] || (ch == 0 && act[ch][0]
                && st.mode[3]));
        end
    endgenerate

    // software clear mask on the flag register
    assign clr = (req.wr && req.addr == `PWM_OFF_FLAGS)
        ? req.wdata[3:0] : 4'h0;

    // events raised this cycle
    always_comb
    begin
        set = 4'h0;
        set[`PWM_FLAG_COMPA] = match[0];
        set[`PWM_FLAG_COMPB] = match[1];
        if (dual && tick && atTop)
        begin
            // top-source flag at top in both modes
            if (st.mode == `PWM_MODE_PFC_A || st.mode == `PWM_MODE_PC_A)
                set[`PWM_FLAG_COMPA] = 1'b1;
            else if (st.mode == `PWM_MODE_PFC_CAP
                || st.mode == `PWM_MODE_PC_CAP)
                set[`PWM_FLAG_CAPTURE] = 1'b1;
        end
        if (dual && tick && atBottom)
            set[`PWM_FLAG_OVERFLOW] = 1'b1;
    end

    // next-state logic
    always_comb
    begin
        next_st = st;
        next_st.psc = (st.clkSel == `PWM_CLK_STOP)
            ? 10'h000 : st.psc + 10'h001;

        // dual-slope counting, one step per tick
        if (dual && tick)
        begin
            if (atTop)
            begin
                next_st.dir = COUNT_DOWN;
                next_st.cnt = st.cnt - 16'h0001;
            end
            else if (atBottom)
            begin
                next_st.dir = COUNT_UP;
                next_st.cnt = 16'h0001;
            end
            else if (st.dir == COUNT_UP)
                next_st.cnt = st.cnt + 16'h0001;
            else
                next_st.cnt = st.cnt - 16'h0001;
        end

        // double buffer update point: top or bottom by mode
        if (!dual)
            next_st.actCmp = st.bufCmp;
        else if (tick && ((!pfc && atTop) || (pfc && atBottom)))
            next_st.actCmp = st.bufCmp;

        // wave outputs on compare matches
        for (int ch = 0; ch < 2; ch++)
        begin
            if (match[ch])
            begin
                case (act[ch])
                    `PWM_ACT_NONINV:
                        next_st.wave[ch] = !upEff;
                    `PWM_ACT_INV:
                        next_st.wave[ch] = upEff;
                    `PWM_ACT_TOGGLE:
                        if (connected[ch])
                            next_st.wave[ch] = !st.wave[ch];
                    default: next_st.wave[ch] = st.wave[ch];
                endcase
            end
        end

        // sticky flags; a new event beats a clear
        next_st.flags = (st.flags & ~clr) | set;

        // register writes; a count write overrides the tick step
        if (req.wr)
        begin
            case (req.addr)
                `PWM_OFF_CTRL:
                begin
                    next_st.mode = req.wdata[`PWM_CTRL_MODE_MSB:
                        `PWM_CTRL_MODE_LSB];
                    next_st.actA = req.wdata[`PWM_CTRL_ACTA_MSB:
                        `PWM_CTRL_ACTA_LSB];
                    next_st.actB = req.wdata[`PWM_CTRL_ACTB_MSB:
                        `PWM_CTRL_ACTB_LSB];
                    next_st.clkSel = req.wdata[`PWM_CTRL_CLK_MSB:
                        `PWM_CTRL_CLK_LSB];
                end
                `PWM_OFF_COMPA:
                    next_st.bufCmp[0] = req.wdata & fixMask;
                `PWM_OFF_COMPB:
                    next_st.bufCmp[1] = req.wdata & fixMask;
                // capture top is not buffered: takes effect at once
                `PWM_OFF_CAPTOP: next_st.capTop = req.wdata;
                `PWM_OFF_COUNT: next_st.cnt = req.wdata;
                `PWM_OFF_PINDIR: next_st.pinDir = req.wdata[1:0];
                default: next_st.capTop = next_st.capTop;
            endcase
        end

        // pin drive only where the direction bit selects output
        next_st.pins.level = next_st.wave & connected;
        next_st.pins.enable = st.pinDir & connected;

        // read data live for exactly one cycle after the strobe
        next_st.rdata = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                `PWM_OFF_CTRL:
                    next_st.rdata = {5'h00, st.clkSel, st.actB, st.actA,
                        st.mode};
                `PWM_OFF_COMPA: next_st.rdata = st.bufCmp[0];
                `PWM_OFF_COMPB: next_st.rdata = st.bufCmp[1];
                `PWM_OFF_CAPTOP: next_st.rdata = st.capTop;
                `PWM_OFF_COUNT: next_st.rdata = st.cnt;
                `PWM_OFF_FLAGS: next_st.rdata = {12'h000, st.flags};
                `PWM_OFF_PINDIR: next_st.rdata = {14'h0000, st.pinDir};
                default: next_st.rdata = 16'h0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st <= '0;
            st.mode <= 4'(`PWM_RST_CTRL);
            st.flags <= `PWM_RST_FLAGS;
            st.pinDir <= `PWM_RST_PINDIR;
            st.capTop <= `PWM_RST_WORD;
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign flags = st.flags;
    assign pins = st.pins;

endmodule : dual_slope_pwm_timer16

/* File: pkg/dual_slope_pwm_cfg.svh */
// constants for the dual-slope pwm timer: offsets, fields, resets, codes
`ifndef DUAL_SLOPE_PWM_CFG_SVH
`define DUAL_SLOPE_PWM_CFG_SVH

// register offsets (byte addresses)
`define PWM_OFF_CTRL 8'h00
`define PWM_OFF_COMPA 8'h04
`define PWM_OFF_COMPB 8'h08
`define PWM_OFF_CAPTOP 8'h0c
`define PWM_OFF_COUNT 8'h10
`define PWM_OFF_FLAGS 8'h14
`define PWM_OFF_PINDIR 8'h18

// control register field positions
`define PWM_CTRL_MODE_LSB 0
`define PWM_CTRL_MODE_MSB 3
`define PWM_CTRL_ACTA_LSB 4
`define PWM_CTRL_ACTA_MSB 5
`define PWM_CTRL_ACTB_LSB 6
`define PWM_CTRL_ACTB_MSB 7
`define PWM_CTRL_CLK_LSB 8
`define PWM_CTRL_CLK_MSB 10

// flag register bit positions
`define PWM_FLAG_COMPA 0
`define PWM_FLAG_COMPB 1
`define PWM_FLAG_CAPTURE 2
`define PWM_FLAG_OVERFLOW 3

// reset values
`define PWM_RST_CTRL 11'h000
`define PWM_RST_WORD 16'h0000
`define PWM_RST_FLAGS 4'h0
`define PWM_RST_PINDIR 2'h0

// waveform modes handled here
`define PWM_MODE_PC8 4'h1
`define PWM_MODE_PC9 4'h2
`define PWM_MODE_PC10 4'h3
`define PWM_MODE_PFC_CAP 4'h8
`define PWM_MODE_PFC_A 4'h9
`define PWM_MODE_PC_CAP 4'ha
`define PWM_MODE_PC_A 4'hb

// fixed top values
`define PWM_TOP_8BIT 16'h00ff
`define PWM_TOP_9BIT 16'h01ff
`define PWM_TOP_10BIT 16'h03ff

// output action codes
`define PWM_ACT_OFF 2'h0
`define PWM_ACT_TOGGLE 2'h1
`define PWM_ACT_NONINV 2'h2
`define PWM_ACT_INV 2'h3

// prescaler select codes and divide masks (divide factor minus one)
`define PWM_CLK_STOP 3'h0
`define PWM_CLK_DIV1 3'h1
`define PWM_CLK_DIV8 3'h2
`define PWM_CLK_DIV64 3'h3
`define PWM_CLK_DIV256 3'h4
`define PWM_CLK_DIV1024 3'h5
`define PWM_CLK_DIV16 3'h6
`define PWM_CLK_DIV32 3'h7
`define PWM_MASK_DIV1 10'h000
`define PWM_MASK_DIV8 10'h007
`define PWM_MASK_DIV16 10'h00f
`define PWM_MASK_DIV32 10'h01f
`define PWM_MASK_DIV64 10'h03f
`define PWM_MASK_DIV256 10'h0ff
`define PWM_MASK_DIV1024 10'h3ff

`endif

/* File: pkg/dual_slope_pwm_pkg.sv */
// types for the dual-slope pwm timer
package dual_slope_pwm_pkg;

    // count direction of the dual-slope counter
    typedef enum logic {
        COUNT_UP = 1'b0,
        COUNT_DOWN = 1'b1
    } countDir_e;

    // one register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } regReq_s;

    // pin drive for the two wave outputs
    typedef struct packed {
        logic [1:0] level;
        logic [1:0] enable;
    } pinDrive_s;

    // whole state of the timer
    typedef struct packed {
        logic [9:0] psc;
        logic [15:0] cnt;
        countDir_e dir;
        logic [3:0] mode;
        logic [1:0] actA;
        logic [1:0] actB;
        logic [2:0] clkSel;
        logic [1:0][15:0] bufCmp;
        logic [1:0][15:0] actCmp;
        logic [15:0] capTop;
        logic [3:0] flags;
        logic [1:0] wave;
        logic [1:0] pinDir;
        pinDrive_s pins;
        logic [15:0] rdata;
    } timerState_s;

endpackage : dual_slope_pwm_pkg

/* File: test/pwm_timer_properties.sv */
// port assertions for the dual-slope pwm timer
`timescale 1ns/1ps
`include "dual_slope_pwm_cfg.svh"

module pwm_timer_properties
    import dual_slope_pwm_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic srst, // sync reset
    input wire regReq_s req, // register request
    input wire logic [15:0] rdata, // read data
    input wire logic [3:0] flags, // event flags
    input wire pinDrive_s pins // pin drive
);
    logic [10:0] ctrlSh;
    logic [1:0] dirSh;
    logic [1:0] calm;
    logic wrCtrl;
    logic wrCnt;
    logic rdCnt;
    logic runFast;
    logic [3:0] clr;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    // bus decodes
    assign wrCtrl = req.wr && req.addr == `PWM_OFF_CTRL;
    assign wrCnt = req.wr && req.addr == `PWM_OFF_COUNT;
    assign rdCnt = req.rd && req.addr == `PWM_OFF_COUNT;
    assign clr = req.wr && req.addr == `PWM_OFF_FLAGS ? req.wdata[3:0] : 4'h0;
    assign runFast = ctrlSh[10:8] == 3'h1
        && ctrlSh[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};

    // shadows of software writes, so no peeking inside the design
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctrlSh <= 11'h000;
            dirSh <= 2'h0;
            calm <= 2'h0;
        end
        else
        begin
            if (wrCtrl)
                ctrlSh <= req.wdata[10:0];
            if (req.wr && req.addr == `PWM_OFF_PINDIR)
                dirSh <= req.wdata[1:0];
            // saturates at 3: config then settled for a full tick
            calm <= wrCtrl || wrCnt ? 2'h0 : calm + {1'b0, calm != 2'h3};
        end
    end

    rd_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
        else $error("read data outside its slot");
    rd_unmapped_a: assert property ($past(req.rd && req.addr == 8'h1c)
        |-> rdata == 16'h0000) else $error("unmapped read not zero");
    rd_pindir_a: assert property ($past(req.rd && req.addr == `PWM_OFF_PINDIR)
        |-> rdata == {14'h0000, $past(dirSh)}) else $error("pindir readback");
    flag_sticky_a: assert property (
        ($past(flags) & ~$past(clr) & ~flags) == 4'h0)
        else $error("flag dropped without clear");
    stop_quiet_a: assert property (
        ctrlSh[10:8] == 3'h0 && $past(ctrlSh[10:8]) == 3'h0
        |-> (flags & ~$past(flags)) == 4'h0) else $error("flag while stopped");
    count_step_a: assert property (
        $past(rdCnt) && $past(rdCnt, 2) && runFast && calm == 2'h3
        |-> rdata - $past(rdata) inside {16'h0001, 16'hffff})
        else $error("counter step not one");
    pin_off_a: assert property (
        $past(ctrlSh[7]) == 1'b0
        |-> !pins.level[1] && !pins.enable[1]) else $error("pin b driven");
    dir_gate_a: assert property (
        (pins.enable & ~(dirSh | $past(dirSh) | $past(dirSh, 2))) == 2'h0)
        else $error("pin driven as input");

    // main scenarios reached
    cover property ($rose(flags[3]));
    cover property ($rose(pins.enable[1]));
    cover property ($past(rdCnt) && rdCnt && runFast);
endmodule : pwm_timer_properties

/* File: test/pin_load_model.sv */
// load on the two wave pins; an undriven pin floats
`timescale 1ns/1ps

module pin_load_model
    import dual_slope_pwm_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire pinDrive_s pins, // drive from the timer
    output logic [1:0] line, // level on each pin
    output logic [1:0] driven // pin being driven
);
    logic [1:0] last = 2'h0;

    // floating pin flips each cycle so a stale level never passes
    assign driven = pins.enable;
    assign line = (pins.level & pins.enable)
        | (~last & ~pins.enable);

    // last level seen
    always_ff @(posedge clk_sys)
    begin
        last <= line;
    end
endmodule : pin_load_model

/* File: test/tb_dual_slope_pwm_timer16.sv */
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
`include "dual_slope_pwm_cfg.svh"

module tb_dual_slope_pwm_timer16
    import dual_slope_pwm_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    regReq_s req = '0;
    logic [15:0] rdata;
    logic [3:0] flags;
    pinDrive_s pins;
    logic [1:0] line;
    logic [1:0] driven;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] x;
    logic [3:0] modeList [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
    int divList [8] = '{0, 1, 8, 64, 256, 1024, 16, 32};
    // act, compare, high cycles out of 12
    logic [15:0] dutyList [7] = '{16'h2104, 16'h3108, 16'h2000, 16'h230c,
        16'h300c, 16'h3300, 16'h3500};

    dual_slope_pwm_timer16 #(.EXTRA_DIV(1'b1)) dual_slope_pwm_timer16_i (
        .clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
        .flags(flags), .pins(pins));
    pin_load_model pin_load_model_i (.clk_sys(clk_sys), .pins(pins),
        .line(line), .driven(driven));

    initial forever #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // bus cycles: strobe one cycle, data the cycle after a read
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // four back-to-back counter reads, each one step apart
    task automatic burst;
        logic [15:0] prev;
        @(posedge clk_sys);
        req <= '{addr: `PWM_OFF_COUNT, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            if (i == 3)
                req.rd <= 1'b0;
            #1 w = rdata;
            if (i > 0)
                chk({15'h0000, w - prev inside {16'h0001, 16'hffff}},
                    16'h0001);
            prev = w;
        end
    endtask : burst

    task automatic t_bus;
        rd(`PWM_OFF_CTRL, v);
        chk(v, 16'h0000);
        rd(`PWM_OFF_FLAGS, v);
        chk(v, 16'h0000);
        rd(8'h1c, v);
        chk(v, 16'h0000);
        wr(`PWM_OFF_COMPB, 16'h1234);
        rd(`PWM_OFF_COMPB, v);
        chk(v, 16'h1234);
    endtask : t_bus

    task automatic t_mask;
        for (int m = 1; m < 4; m++)
        begin
            wr(`PWM_OFF_CTRL, 16'(m));
            wr(`PWM_OFF_COMPA, 16'hffff);
            rd(`PWM_OFF_COMPA, v);
            chk(v, 16'hffff >> (9 - m));
        end
    endtask : t_mask

    // every mode: overflow; top flag source and compare b beyond top in the four variable-top modes
    task automatic t_modes;
        foreach (modeList[i])
        begin
            wr(`PWM_OFF_CTRL, 16'h0000);
            wr(`PWM_OFF_COMPA, 16'h0003);
            wr(`PWM_OFF_COMPB, 16'h0005);
            wr(`PWM_OFF_CAPTOP, 16'h0003);
            wr(`PWM_OFF_COUNT, 16'h0000);
            wr(`PWM_OFF_FLAGS, 16'h000f);
            wr(`PWM_OFF_CTRL, {12'h010, modeList[i]});
            repeat (2100) @(posedge clk_sys);
            burst;
            wr(`PWM_OFF_CTRL, {12'h000, modeList[i]});
            rd(`PWM_OFF_FLAGS, v);
            x = modeList[i] < 4'h8 ? 16'hb : modeList[i][0] ? 16'h9 : 16'hd;
            chk(v, x);
        end
    endtask : t_modes

    // three ticks apart differ, six ticks apart repeat
    task automatic t_presc;
        wr(`PWM_OFF_CTRL, 16'h0000);
        wr(`PWM_OFF_COMPA, 16'h0003);
        wr(`PWM_OFF_COUNT, 16'h0000);
        for (int s = 1; s < 8; s++)
        begin
            wr(`PWM_OFF_CTRL, {5'h00, 3'(s), 8'h09});
            rd(`PWM_OFF_COUNT, v);
            repeat (3 * divList[s] - 2) @(posedge clk_sys);
            rd(`PWM_OFF_COUNT, w);
            repeat (3 * divList[s] - 2) @(posedge clk_sys);
            rd(`PWM_OFF_COUNT, x);
            chk({15'h0000, v !== w}, 16'h0001);
            chk(x, v);
        end
    endtask : t_presc

    task automatic t_duty;
        int high;
        wr(`PWM_OFF_CTRL, 16'h0000);
        wr(`PWM_OFF_COMPA, 16'h0003);
        wr(`PWM_OFF_PINDIR, 16'h0002);
        rd(`PWM_OFF_PINDIR, v);
        chk(v, 16'h0002);
        foreach (dutyList[i])
        begin
            wr(`PWM_OFF_CTRL, {8'h01, dutyList[i][13:12], 6'h09});
            wr(`PWM_OFF_COMPB, {12'h000, dutyList[i][11:8]});
            repeat (14) @(posedge clk_sys);
            high = 0;
            repeat (12)
            begin
                @(posedge clk_sys);
                #1 high += line[1];
            end
            chk(16'(high), {8'h00, dutyList[i][7:0]});
            chk({15'h0000, driven[1]}, 16'h0001);
        end
        wr(`PWM_OFF_PINDIR, 16'h0000);
        repeat (3) @(posedge clk_sys);
        #1 chk({14'h0000, pins.enable}, 16'h0000);
    endtask : t_duty

    // action one: A toggles at top with mode bit 3, B stays off
    task automatic t_toggle;
        int high;
        wr(`PWM_OFF_PINDIR, 16'h0003);
        wr(`PWM_OFF_CTRL, 16'h0159);
        repeat (14) @(posedge clk_sys);
        high = 0;
        repeat (12)
        begin
            @(posedge clk_sys);
            #1 high += line[0];
        end
        chk(16'(high), 16'h0006);
        chk({14'h0000, driven}, 16'h0001);
        // mode bit 3 clear: toggle leaves A disconnected
        wr(`PWM_OFF_CTRL, 16'h0151);
        repeat (3) @(posedge clk_sys);
        #1 chk({14'h0000, driven}, 16'h0000);
        wr(`PWM_OFF_PINDIR, 16'h0000);
    endtask : t_toggle

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        t_bus;
        t_mask;
        t_modes;
        t_presc;
        t_duty;
        t_toggle;
        give_verdict;
    end

    // run is about 24k cycles, so 60k means a hang
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict;
    end
endmodule : tb_dual_slope_pwm_timer16

bind dual_slope_pwm_timer16 pwm_timer_properties pwm_timer_properties_i (
    .clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
    .flags(flags), .pins(pins));
